// ### rtl/iocc_pkg.sv
package iocc_pkg;

  // ----------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------
  localparam int          IO_ADDR_W      = 16;
  localparam int          MEM_ADDR_W     = 20;
  localparam int          NUM_BLOCKS     = 8;
  localparam int          BLOCK_SIZE     = 8192;
  localparam int          BLK_W          = 3;
  localparam int          BLK_LSB        = 13;
  localparam logic [15:0] INT_LIMIT      = 16'h0100;
  localparam int          AUX_ADDR_W     = 6;
  localparam int          DATA_W         = 8;

  // ----------------------------------------------------------------
  // Cycle lengths and wait-state extra clocks
  // ----------------------------------------------------------------
  localparam logic [4:0]  EXT_BASE_CLKS  = 5'h03;
  localparam logic [4:0]  INT_CLKS       = 5'h02;
  localparam logic [4:0]  WS_CODE0_CLKS  = 5'h00;
  localparam logic [4:0]  WS_CODE1_CLKS  = 5'h01;
  localparam logic [4:0]  WS_CODE2_CLKS  = 5'h06;
  localparam logic [4:0]  WS_CODE3_CLKS  = 5'h0e;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_WAIT       = 8'h04;
  localparam logic [7:0]  OFS_PE_FUNC    = 8'h08;
  localparam logic [7:0]  OFS_PE_BLK     = 8'h0c;
  localparam logic [7:0]  OFS_STATUS     = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_AUX_EN    = 0;
  localparam int          ST_COUNT_LSB   = 0;
  localparam int          ST_BLK_LSB     = 16;
  localparam int          ST_AUX_BIT     = 30;
  localparam int          ST_BUSY_BIT    = 31;
  localparam logic        RST_AUX_EN     = 1'b0;
  localparam logic [15:0] RST_WAIT       = 16'h0000;
  localparam logic [15:0] RST_PE_FUNC    = 16'h0000;
  localparam logic [23:0] RST_PE_BLK     = 24'h00_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PE_OFF,
    PE_CHIP_SEL,
    PE_RD_STROBE,
    PE_WR_STROBE
  } iocc_pe_func_t;

  typedef enum logic {
    PH_IDLE,
    PH_BUSY
  } iocc_phase_t;

  typedef struct packed {
    logic                  io_prefix;
    logic                  write;
    logic [MEM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
  } iocc_req_t;

  typedef struct packed {
    logic              done;
    logic [DATA_W-1:0] rdata;
  } iocc_rsp_t;

endpackage

// ### rtl/iocc_pe_pin.sv
`timescale 1ns/1ps
module iocc_pe_pin
  import iocc_pkg::*;
(
  input  wire logic             busy_in,
  input  wire logic             write_in,
  input  wire logic [BLK_W-1:0] cur_blk_in,
  input  wire logic [1:0]       func_in,
  input  wire logic [BLK_W-1:0] sel_blk_in,
  output logic                  pin_n_out,
  output logic                  pin_oe_n_out
);

  // ----------------------------------------------------------------
  // Active only inside the assigned block
  // ----------------------------------------------------------------
  logic hit;

  always_comb begin
    hit          = busy_in && (cur_blk_in == sel_blk_in);
    pin_oe_n_out = (iocc_pe_func_t'(func_in) == PE_OFF);
    unique case (iocc_pe_func_t'(func_in))
      PE_CHIP_SEL:  pin_n_out = !hit;
      PE_RD_STROBE: pin_n_out = !(hit && !write_in);
      PE_WR_STROBE: pin_n_out = !(hit && write_in);
      PE_OFF:       pin_n_out = 1'b1;
    endcase
  end

endmodule // iocc_pe_pin

// ### rtl/iocc_io_bus_ctrl.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Only requests carrying the I/O prefix run I/O cycles; others go to memory.
// - I/O space is 64K locations on 16 address lines, apart from memory.
// - Dedicated active-low I/O read and write strobes mark each I/O cycle.
// - An external I/O cycle without wait states lasts exactly 3 clocks.
// - Wait states add 1, 6 or 14 clocks, nothing else.
// - The I/O space is split into 8 blocks of 8192 addresses.
// - Each block has its own wait-state setting, applied to its external cycles.
// - Port E pins can be block chip select, read or write strobe.
// - The lowest 256 I/O addresses belong to internal peripherals.
// - Cycles to internal peripherals last 2 clocks.
// - The auxiliary bus is off after reset until software enables it.
// - Auxiliary data uses port A, eight bits; auxiliary address uses port B, six.
// - The auxiliary bus shares the ordinary I/O strobes; no own controls.
// - With auxiliary bus on, each I/O cycle runs on both buses.
// - Memory cycles leave the auxiliary bus untouched.
// - Auxiliary address holds its last value until the next I/O cycle.
// - Auxiliary data lines float whenever no I/O cycle runs.
// - Enabling the auxiliary bus disables the slave port sharing its pins.
module iocc_io_bus_ctrl
  import iocc_pkg::*;
#(
  parameter int PE_PINS = 8
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  // APB register port
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic                       pready_out,
  output logic [31:0]                prdata_out,
  output logic                       pslverr_out,
  // Core request and answer
  input  wire logic                  req_valid_in,
  input  wire iocc_req_t             req_in,
  output logic                       req_ready_out,
  output iocc_rsp_t                  rsp_out,
  output logic                       mem_fwd_out,
  // Internal peripherals
  output logic                       int_sel_out,
  output logic                       int_write_out,
  input  wire logic [DATA_W-1:0]     int_rdata_in,
  // Main I/O bus pins
  output logic [IO_ADDR_W-1:0]       io_addr_out,
  output logic [DATA_W-1:0]          io_data_out,
  output logic                       io_data_oe_n_out,
  input  wire logic [DATA_W-1:0]     io_data_in,
  output logic                       io_read_strobe_n_out,
  output logic                       io_write_strobe_n_out,
  // Port E strobes
  output logic [PE_PINS-1:0]         pe_n_out,
  output logic [PE_PINS-1:0]         pe_oe_n_out,
  // Auxiliary bus on ports A and B
  output logic [DATA_W-1:0]          aux_data_out,
  output logic                       aux_data_oe_n_out,
  input  wire logic [DATA_W-1:0]     aux_data_in,
  output logic [AUX_ADDR_W-1:0]      aux_addr_out,
  output logic                       aux_addr_oe_n_out,
  output logic                       slave_port_en_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PE_PINS < 1 || PE_PINS > 8) begin : g_pe_check
    $error("PE_PINS must lie between 1 and 8");
  end
  if (NUM_BLOCKS * BLOCK_SIZE != 2 ** IO_ADDR_W) begin : g_space_check
    $error("Blocks must tile the I/O space exactly");
  end
  if (BLK_LSB + BLK_W != IO_ADDR_W || 2 ** BLK_W != NUM_BLOCKS) begin : g_blk_check
    $error("Block number must be the top address bits");
  end
  if (AUX_ADDR_W > BLK_LSB || int'(INT_LIMIT) > BLOCK_SIZE) begin : g_range_check
    $error("Auxiliary and internal ranges must lie inside one block");
  end
  if (int'(EXT_BASE_CLKS) + int'(WS_CODE3_CLKS) > 31) begin : g_len_check
    $error("Longest cycle must fit the cycle counter");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    iocc_phase_t           phase;
    logic [4:0]            cnt;
    logic [IO_ADDR_W-1:0]  addr;
    logic                  write;
    logic                  internal;
    logic [DATA_W-1:0]     wdata;
    logic [DATA_W-1:0]     rdata;
    logic                  done;
    logic                  mem_fwd;
    logic                  rd_n;
    logic                  wr_n;
    logic [PE_PINS-1:0]    pe_n;
    logic [AUX_ADDR_W-1:0] aux_addr;
    logic                  aux_en;
    logic [15:0]           wait_cfg;
    logic [15:0]           pe_func;
    logic [23:0]           pe_blk;
    logic [15:0]           io_count;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [DATA_W-1:0]     main_d1;
    logic [DATA_W-1:0]     main_d2;
    logic [DATA_W-1:0]     aux_d1;
    logic [DATA_W-1:0]     aux_d2;
  } iocc_state_t;

  iocc_state_t cur;
  iocc_state_t next_cur;

  localparam iocc_state_t RST_STATE = '{
    phase:    PH_IDLE,
    cnt:      5'h00,
    addr:     16'h0000,
    write:    1'b0,
    internal: 1'b0,
    wdata:    8'h00,
    rdata:    8'h00,
    done:     1'b0,
    mem_fwd:  1'b0,
    rd_n:     1'b1,
    wr_n:     1'b1,
    pe_n:     '1,
    aux_addr: 6'h00,
    aux_en:   RST_AUX_EN,
    wait_cfg: RST_WAIT,
    pe_func:  RST_PE_FUNC,
    pe_blk:   RST_PE_BLK,
    io_count: 16'h0000,
    prdata:   32'h0000_0000,
    pslverr:  1'b0,
    main_d1:  8'h00,
    main_d2:  8'h00,
    aux_d1:   8'h00,
    aux_d2:   8'h00
  };

  // ----------------------------------------------------------------
  // Wait-state code to extra clocks
  // ----------------------------------------------------------------
  function automatic logic [4:0] wait_clks(input logic [1:0] code);
    unique case (code)
      2'd0: wait_clks = WS_CODE0_CLKS;
      2'd1: wait_clks = WS_CODE1_CLKS;
      2'd2: wait_clks = WS_CODE2_CLKS;
      2'd3: wait_clks = WS_CODE3_CLKS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus state of the coming clock
  // ----------------------------------------------------------------
  logic             start;
  logic             next_busy;
  logic             next_write;
  logic [BLK_W-1:0] next_blk;

  // Kept apart from the next-state logic so no loop runs through the pins
  always_comb begin
    start      = req_valid_in && req_in.io_prefix && (cur.phase == PH_IDLE);
    next_busy  = start || ((cur.phase == PH_BUSY) && (cur.cnt != 5'h00));
    next_write = start ? req_in.write : cur.write;
    next_blk   = start ? req_in.addr[BLK_LSB +: BLK_W] : cur.addr[BLK_LSB +: BLK_W];
  end

  // ----------------------------------------------------------------
  // Port E pin decoders, registered with the strobes
  // ----------------------------------------------------------------
  logic [PE_PINS-1:0] pe_n_next;
  logic [PE_PINS-1:0] pe_oe_n;

  for (genvar i = 0; i < PE_PINS; i++) begin : g_pe
    iocc_pe_pin u_pin (
      .busy_in      (next_busy),
      .write_in     (next_write),
      .cur_blk_in   (next_blk),
      .func_in      (cur.pe_func[2*i +: 2]),
      .sel_blk_in   (cur.pe_blk[BLK_W*i +: BLK_W]),
      .pin_n_out    (pe_n_next[i]),
      .pin_oe_n_out (pe_oe_n[i])
    );
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic             accept;
  logic             apb_setup;
  logic             apb_write;
  logic [BLK_W-1:0] req_blk;
  logic [4:0]       req_len;
  logic             req_int;

  always_comb begin
    next_cur  = cur;
    accept    = req_valid_in && (cur.phase == PH_IDLE);
    apb_setup = psel_in && !penable_in;
    apb_write = psel_in && penable_in && pwrite_in;
    req_blk   = req_in.addr[BLK_LSB +: BLK_W];
    req_int   = (req_in.addr[IO_ADDR_W-1:0] < INT_LIMIT);
    if (req_int) begin
      req_len = INT_CLKS;
    end else begin
      req_len = EXT_BASE_CLKS + wait_clks(cur.wait_cfg[2*req_blk +: 2]);
    end

    // Pin data passes two flip-flops before use
    next_cur.main_d1 = io_data_in;
    next_cur.main_d2 = cur.main_d1;
    next_cur.aux_d1  = aux_data_in;
    next_cur.aux_d2  = cur.aux_d1;

    next_cur.done    = 1'b0;
    next_cur.mem_fwd = 1'b0;

    unique case (cur.phase)
      PH_IDLE: begin
        if (accept && req_in.io_prefix) begin
          next_cur.phase    = PH_BUSY;
          next_cur.cnt      = req_len - 5'h01;
          next_cur.addr     = req_in.addr[IO_ADDR_W-1:0];
          next_cur.write    = req_in.write;
          next_cur.internal = req_int;
          next_cur.wdata    = req_in.wdata;
          next_cur.aux_addr = req_in.addr[AUX_ADDR_W-1:0];
        end else if (accept) begin
          next_cur.mem_fwd  = 1'b1;
        end
      end
      PH_BUSY: begin
        if (cur.cnt == 5'h00) begin
          next_cur.phase    = PH_IDLE;
          next_cur.done     = 1'b1;
          next_cur.io_count = cur.io_count + 16'h0001;
          if (!cur.write) begin
            if (cur.internal) begin
              next_cur.rdata = int_rdata_in;
            end else if (cur.aux_en) begin
              next_cur.rdata = cur.aux_d2;
            end else begin
              next_cur.rdata = cur.main_d2;
            end
          end
        end else begin
          next_cur.cnt = cur.cnt - 5'h01;
        end
      end
    endcase

    // Strobes cover every clock of an I/O cycle
    next_cur.rd_n = !((next_cur.phase == PH_BUSY) && !next_cur.write);
    next_cur.wr_n = !((next_cur.phase == PH_BUSY) && next_cur.write);
    next_cur.pe_n = pe_n_next;

    // APB: read data prepared in the setup cycle
    if (apb_setup) begin
      next_cur.pslverr = 1'b0;
      next_cur.prdata  = 32'h0000_0000;
      unique case (paddr_in)
        OFS_CTRL:    next_cur.prdata[CTRL_AUX_EN] = cur.aux_en;
        OFS_WAIT:    next_cur.prdata[15:0] = cur.wait_cfg;
        OFS_PE_FUNC: next_cur.prdata[15:0] = cur.pe_func;
        OFS_PE_BLK:  next_cur.prdata[23:0] = cur.pe_blk;
        OFS_STATUS: begin
          next_cur.prdata[ST_COUNT_LSB +: 16]   = cur.io_count;
          next_cur.prdata[ST_BLK_LSB +: BLK_W]  = cur.addr[BLK_LSB +: BLK_W];
          next_cur.prdata[ST_AUX_BIT]           = cur.aux_en;
          next_cur.prdata[ST_BUSY_BIT]          = (cur.phase == PH_BUSY);
        end
        default:     next_cur.pslverr = 1'b1;
      endcase
    end

    // Configuration changes only between I/O cycles take hold cleanly
    if (apb_write) begin
      unique case (paddr_in)
        OFS_CTRL:    next_cur.aux_en   = pwdata_in[CTRL_AUX_EN];
        OFS_WAIT:    next_cur.wait_cfg = pwdata_in[15:0];
        OFS_PE_FUNC: next_cur.pe_func  = pwdata_in[15:0];
        OFS_PE_BLK:  next_cur.pe_blk   = pwdata_in[23:0];
        default:     next_cur.pe_func  = next_cur.pe_func;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cur <= RST_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // APB and core answers
  // ----------------------------------------------------------------
  always_comb begin
    pready_out    = 1'b1;
    prdata_out    = cur.prdata;
    pslverr_out   = cur.pslverr;
    req_ready_out = (cur.phase == PH_IDLE);
    rsp_out.done  = cur.done;
    rsp_out.rdata = cur.rdata;
    mem_fwd_out   = cur.mem_fwd;
  end

  // ----------------------------------------------------------------
  // Main I/O bus and internal peripherals
  // ----------------------------------------------------------------
  logic busy;

  always_comb begin
    busy                  = (cur.phase == PH_BUSY);
    int_sel_out           = busy && cur.internal;
    int_write_out         = busy && cur.internal && cur.write;
    io_addr_out           = cur.addr;
    io_data_out           = cur.wdata;
    io_data_oe_n_out      = !(busy && cur.write);
    io_read_strobe_n_out  = cur.rd_n;
    io_write_strobe_n_out = cur.wr_n;
    pe_n_out              = cur.pe_n;
    pe_oe_n_out           = pe_oe_n;
  end

  // ----------------------------------------------------------------
  // Auxiliary bus, whose pins double as the slave port
  // ----------------------------------------------------------------
  always_comb begin
    aux_data_out          = cur.wdata;
    aux_data_oe_n_out     = !(cur.aux_en && busy && cur.write);
    aux_addr_out          = cur.aux_addr;
    aux_addr_oe_n_out     = !cur.aux_en;
    slave_port_en_out     = !cur.aux_en;
  end

endmodule // iocc_io_bus_ctrl

// ### tb/iocc_io_bus_ctrl_assertions.sv
`timescale 1ns/1ps
module iocc_io_bus_ctrl_assertions
  import iocc_pkg::*;
#(
  parameter int PE_PINS = 8
) (
  input wire logic                  clock_in,
  input wire logic                  rst_n_in,
  input wire iocc_rsp_t             rsp_out,
  input wire logic                  mem_fwd_out,
  input wire logic                  int_sel_out,
  input wire logic [IO_ADDR_W-1:0]  io_addr_out,
  input wire logic [DATA_W-1:0]     io_data_out,
  input wire logic                  io_read_strobe_n_out,
  input wire logic                  io_write_strobe_n_out,
  input wire logic [PE_PINS-1:0]    pe_n_out,
  input wire logic [DATA_W-1:0]     aux_data_out,
  input wire logic                  aux_data_oe_n_out,
  input wire logic [AUX_ADDR_W-1:0] aux_addr_out,
  input wire logic                  aux_addr_oe_n_out,
  input wire logic                  slave_port_en_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  logic       strobes_idle;
  logic [4:0] low_len;

  assign strobes_idle = io_read_strobe_n_out & io_write_strobe_n_out;

  // Length of the current strobe pulse
  always_ff @(posedge clock_in) begin
    low_len <= (!rst_n_in || strobes_idle) ? 5'h00 : low_len + 5'h01;
  end

  property p_excl; io_read_strobe_n_out | io_write_strobe_n_out; endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_min; $fell(strobes_idle) |-> !strobes_idle [*2]; endproperty
  a_min: assert property (p_min) else $error("strobe too short");
  property p_max; !strobes_idle |-> low_len <= 5'h10; endproperty
  a_max: assert property (p_max) else $error("strobe too long");
  property p_done; $rose(strobes_idle) |-> rsp_out.done; endproperty
  a_done: assert property (p_done) else $error("no done at strobe end");
  property p_int; int_sel_out |-> io_addr_out < 16'h0100 && !strobes_idle; endproperty
  a_int: assert property (p_int) else $error("internal select misplaced");
  property p_aux_addr; $fell(strobes_idle) |-> aux_addr_out == io_addr_out[5:0]; endproperty
  a_aux_addr: assert property (p_aux_addr) else $error("aux address wrong");
  property p_hold; strobes_idle && $past(strobes_idle) |-> $stable(aux_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("aux address moved");
  property p_mem; mem_fwd_out |-> strobes_idle && $stable(aux_addr_out); endproperty
  a_mem: assert property (p_mem) else $error("memory cycle on aux bus");
  property p_float; !aux_data_oe_n_out |-> !io_write_strobe_n_out && !aux_addr_oe_n_out; endproperty
  a_float: assert property (p_float) else $error("aux data driven idle");
  property p_mirror; !aux_data_oe_n_out |-> aux_data_out == io_data_out; endproperty
  a_mirror: assert property (p_mirror) else $error("aux data differs");
  property p_slave; slave_port_en_out == aux_addr_oe_n_out; endproperty
  a_slave: assert property (p_slave) else $error("slave port with aux bus");
  property p_pe; !(&pe_n_out) |-> !strobes_idle; endproperty
  a_pe: assert property (p_pe) else $error("port pin outside cycle");

  c_aux_rd: cover property ($rose(io_read_strobe_n_out) && !aux_addr_oe_n_out);
  c_wr: cover property ($fell(io_write_strobe_n_out));
  c_mem: cover property (mem_fwd_out);
  c_int: cover property (int_sel_out);
endmodule // iocc_io_bus_ctrl_assertions

bind iocc_io_bus_ctrl iocc_io_bus_ctrl_assertions #(.PE_PINS(PE_PINS)) u_iocc_io_bus_ctrl_assertions (
  .clock_in, .rst_n_in, .rsp_out, .mem_fwd_out, .int_sel_out, .io_addr_out, .io_data_out,
  .io_read_strobe_n_out, .io_write_strobe_n_out, .pe_n_out, .aux_data_out,
  .aux_data_oe_n_out, .aux_addr_out, .aux_addr_oe_n_out, .slave_port_en_out
);

// ### tb/iocc_ext_periph.sv
`timescale 1ns/1ps
module iocc_ext_periph (
  input  wire logic       clock_in,
  input  wire logic       rd_n_in,
  input  wire logic       wr_n_in,
  input  wire logic [5:0] addr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out
);
  logic [7:0] regs [64];
  logic [7:0] last;

  initial begin
    last = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
  end

  // Sixty-four locations decoded from the six address lines
  always @(posedge clock_in) begin
    if (!wr_n_in) regs[addr_in] <= data_in;
    if (!rd_n_in) last <= regs[addr_in];
  end

  // Released bus shows the inverted last value, never a stale copy
  assign data_out = !rd_n_in ? regs[addr_in] : ~last;
endmodule // iocc_ext_periph

// ### tb/iocc_io_bus_ctrl_tb.sv
`timescale 1ns/1ps
module iocc_io_bus_ctrl_tb;
  import iocc_pkg::*;
  logic clock_in = 1'b0, rst_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, int_rdata_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic pready_out, pslverr_out, req_valid_in = 1'b0, req_ready_out, mem_fwd_out, er, aux;
  iocc_req_t req_in = '0;
  iocc_rsp_t rsp_out;
  logic int_sel_out, int_write_out, io_data_oe_n_out, io_read_strobe_n_out;
  logic io_write_strobe_n_out, aux_data_oe_n_out, aux_addr_oe_n_out, slave_port_en_out;
  logic [15:0] io_addr_out, wait_cfg, pe_func, a;
  logic [7:0] io_data_out, io_data_in, aux_data_out, aux_data_in, pe_n_out, pe_oe_n_out;
  logic [5:0] aux_addr_out;
  logic [23:0] pe_blk;
  logic [7:0] shadow [64];
  integer seed = 22;
  int num_errors = 0, total_checks = 0, r;

  always #2 clock_in = ~clock_in;
  assign aux_data_in = io_data_in;

  iocc_io_bus_ctrl #(.PE_PINS(8)) u_iocc_io_bus_ctrl (
    .clock_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pready_out, .prdata_out, .pslverr_out, .req_valid_in, .req_in, .req_ready_out,
    .rsp_out, .mem_fwd_out, .int_sel_out, .int_write_out, .int_rdata_in, .io_addr_out,
    .io_data_out, .io_data_oe_n_out, .io_data_in, .io_read_strobe_n_out,
    .io_write_strobe_n_out, .pe_n_out, .pe_oe_n_out, .aux_data_out, .aux_data_oe_n_out,
    .aux_data_in, .aux_addr_out, .aux_addr_oe_n_out, .slave_port_en_out
  );
  iocc_ext_periph u_iocc_ext_periph (
    .clock_in, .rd_n_in(io_read_strobe_n_out), .wr_n_in(io_write_strobe_n_out),
    .addr_in(aux_addr_out), .data_in(io_data_out), .data_out(io_data_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= ad;
    pwdata_in <= wd;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  function automatic int exp_len(input logic [15:0] ad);
    int ws [4] = '{0, 1, 6, 14};
    if (ad < 16'h0100) return 2;
    return 3 + ws[wait_cfg[2*ad[15:13] +: 2]];
  endfunction

  function automatic logic [7:0] pe_exp(input logic [2:0] b, input logic wr);
    logic [1:0] f;
    pe_exp = 8'hff;
    for (int i = 0; i < 8; i++) begin
      f = pe_func[2*i +: 2];
      if (pe_blk[3*i +: 3] == b && (f == 2'h1 || f == {1'b1, wr})) pe_exp[i] = 1'b0;
    end
  endfunction

  task automatic io_op(input logic pf, input logic wr, input logic [15:0] ad);
    logic [7:0] wd;
    logic [5:0] held;
    int cnt;
    logic intl;
    wd = 8'($random(seed));
    held = aux_addr_out;
    cnt = 0;
    intl = (ad < 16'h0100);
    @(posedge clock_in);
    int_rdata_in <= 8'($random(seed));
    req_valid_in <= 1'b1;
    req_in <= '{pf, wr, {4'h0, ad}, wd};
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    #1;
    if (!pf) begin
      chk({mem_fwd_out, io_read_strobe_n_out, io_write_strobe_n_out}, 3'h7);
      chk(aux_addr_out, held);
      return;
    end
    while (rsp_out.done !== 1'b1) begin
      if ((wr ? io_write_strobe_n_out : io_read_strobe_n_out) === 1'b0) cnt++;
      if (ad >= 16'h0100) chk(pe_n_out, pe_exp(ad[15:13], wr));
      chk(io_addr_out, ad);
      chk({req_ready_out, io_data_oe_n_out}, {1'b0, !wr});
      chk({int_sel_out, int_write_out}, {intl, intl && wr});
      if (wr) chk(io_data_out, wd);
      @(posedge clock_in);
      #1;
    end
    chk(cnt, exp_len(ad));
    chk({pe_n_out, aux_data_oe_n_out}, 9'h1ff);
    if (wr) shadow[ad[5:0]] = wd;
    else chk(rsp_out.rdata, ad < 16'h0100 ? int_rdata_in : shadow[ad[5:0]]);
  endtask

  initial begin
    #50000;
    num_errors++;
    conclude();
  end

  initial begin
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk({rd[30:0], slave_port_en_out}, 32'h0000_0001);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk(er, 1'b1);
    for (r = 0; r < 4; r++) begin
      aux = r[0];
      wait_cfg = (r == 0) ? 16'h0000 : (r == 3) ? 16'hffff : 16'($random(seed));
      pe_func = (r == 0) ? 16'he4e4 : 16'($random(seed));
      pe_blk = (r == 0) ? 24'hff_ffff : 24'($random(seed));
      apb(1'b1, 8'h00, {31'h0, aux});
      apb(1'b1, 8'h04, {16'h0, wait_cfg});
      apb(1'b1, 8'h08, {16'h0, pe_func});
      apb(1'b1, 8'h0c, {8'h0, pe_blk});
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {16'h0, wait_cfg});
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[30], slave_port_en_out, aux_addr_oe_n_out}, {aux, ~aux, ~aux});
      for (int i = 0; i < 8; i++) begin
        chk(pe_oe_n_out[i], !(|pe_func[2*i +: 2]));
      end
      io_op(1'b1, r[0], 16'h00ff);
      io_op(1'b1, r[1], 16'h0100);
      io_op(1'b0, 1'b0, 16'hffff);
      io_op(1'b1, 1'b1, 16'he000 | 16'(r));
      io_op(1'b1, 1'b0, 16'he000 | 16'(r));
      repeat (20) begin
        a = 16'($random(seed));
        if (a[1:0] == 2'h0) a[15:8] = 8'h00;
        io_op(|a[4:2], a[6], a);
      end
    end
    conclude();
  end
endmodule // iocc_io_bus_ctrl_tb
